// ### rtl/dadl_pkg.sv
// constants and types of the detector alarm delay and learning block
package dadl_pkg;
	// ==========================================================
	// timing
	localparam int unsigned CLOCK_HZ        = 200_000_000;  // 5 ns period
	localparam int unsigned TICK_PERIOD_S   = 1;            // one sample per second
	localparam int unsigned TICK_CYCLES     = CLOCK_HZ * TICK_PERIOD_S;
	localparam int unsigned INTERVAL_HOURS  = 36;           // one learning interval
	localparam int unsigned INTERVAL_TICKS  = INTERVAL_HOURS * 3600 / TICK_PERIOD_S;
	localparam int unsigned PERIOD_INTERVALS = 20;          // intervals per learning period
	// ==========================================================
	// sample scaling: obscuration in 0.1 %/m steps, others in whole units
	localparam int unsigned SAMPLE_W        = 8;
	localparam int unsigned WINDOW_SECONDS  = 60;           // pre-alarm averaging window
	localparam int unsigned REPORT_SECONDS  = 4;            // reported obscuration window
	localparam int unsigned EXCESS_SECONDS  = 9;            // excess summing seconds
	localparam logic [3:0]  COUNT_TRIGGER   = 4'h9;         // alarm counter start level
	localparam logic [3:0]  COUNT_MAX       = 4'hf;         // counter saturation
	localparam logic [3:0]  COUNT_UP_SLOW   = 4'h1;         // smoke and combined step up
	localparam logic [3:0]  COUNT_UP_FAST   = 4'h3;         // heat step up
	localparam logic [3:0]  COUNT_DOWN      = 4'h2;         // step down below threshold
	// ==========================================================
	// delay bands, breakpoints in 0.1 %/m
	localparam logic [6:0]  DELAY_LONG      = 7'h2d;        // 45 s
	localparam logic [6:0]  DELAY_MID       = 7'h1e;        // 30 s
	localparam logic [6:0]  DELAY_SHORT     = 7'h12;        // 18 s
	localparam logic [6:0]  DELAY_MIN       = 7'h09;        // 9 s
	localparam logic [6:0]  DELAY_CAP       = 7'h3c;        // 60 s
	localparam logic [6:0]  CANCEL_SECONDS  = 7'h12;        // 18 s
	localparam logic [7:0]  BP_LOW          = 8'h06;        // 0.6
	localparam logic [7:0]  BP_MID          = 8'h08;        // 0.8
	localparam logic [7:0]  BP_HIGH         = 8'h19;        // 2.5
	localparam logic [7:0]  BP_CLEAN_LOW    = 8'h03;        // 0.3
	localparam logic [7:0]  BP_CLEAN_MID    = 8'h04;        // 0.4
	localparam logic [7:0]  BP_CLEAN_HIGH   = 8'h0d;        // 1.3
	// ==========================================================
	// learning levels
	localparam logic [7:0]  LEVEL2_RISE     = 8'h0c;        // 12 per 168 s
	localparam logic [7:0]  LEVEL3_COMB     = 8'h0a;        // 10
	localparam logic [7:0]  LEVEL3_SMOKE    = 8'h19;        // 2.5 %/m
	localparam logic [7:0]  LEVEL3_RISE     = 8'h03;        // 3 per 168 s
	localparam logic [4:0]  ADOPT_COUNT     = 5'h03;        // flagged intervals to adopt
	// ==========================================================
	// types
	typedef enum logic [4:0] {
		ALGO_NORMAL = 5'b00001,
		ALGO_SMOKE  = 5'b00010,
		ALGO_HEATER = 5'b00100,
		ALGO_COOK   = 5'b01000,
		ALGO_CLEAN  = 5'b10000
	} dadl_algo_t;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_DELAY = 3'b010,
		ST_FIRE  = 3'b100
	} dadl_state_t;
	typedef enum logic [2:0] {
		CAUSE_SMOKE = 3'b001,
		CAUSE_HEAT  = 3'b010,
		CAUSE_COMB  = 3'b100
	} dadl_cause_t;
endpackage : dadl_pkg

// ### rtl/dadl_top.sv
// fire judgement back end: alarm counters, alarm delay, learning, reporting
//
// Summary of operation
// - smoke delay band from pre-alarm average
// - smoke-steam adds half the smoke excess
// - pre-alarm average over sixty seconds before crossing
// - smoke excess summed nine seconds after trigger
// - combined delay half sum, full when cooking
// - every delay capped at sixty seconds
// - heat causes use nine seconds; heater ignores rise
// - strong signal ends delay after eighteen seconds
// - start normal, change only through learning
// - level one: obscuration at half threshold
// - level two: rise rate at least twelve
// - level three: combined, smoke and rise limits
// - flag each 36h interval where level exceeded
// - three flagged intervals adopt the level algorithm
// - below three flags return to normal
// - new period keeps flags, refreshes each interval
// - heater uses level two, cooking level three
// - clean only without flags, after one month
// - any flag leaves clean at once
// - report obscuration and temperature every second
// - smoke and combined counters up one, down two
// - heat counter up three, down two
// - fire alarm after delay elapses, or after eighteen seconds on a strong signal
`timescale 1ns/1ps
`default_nettype none
module dadl_top #(
	parameter int unsigned TICK_CYCLES    = dadl_pkg::TICK_CYCLES,
	parameter int unsigned INTERVAL_TICKS = dadl_pkg::INTERVAL_TICKS
) (
	input  wire logic       CLOCK,
	input  wire logic       RESETN,
	input  wire logic       CE,
	input  wire logic [7:0] SMOKE,
	input  wire logic [7:0] TEMP,
	input  wire logic [7:0] RISE,
	input  wire logic [7:0] COMBINED,
	input  wire logic [7:0] SMOKE_THR,
	input  wire logic [7:0] TEMP_THR,
	input  wire logic [7:0] RISE_THR,
	input  wire logic [7:0] COMB_THR,
	output logic            FIRE_ALARM,
	output logic            DELAY_ACTIVE,
	output logic [2:0]      ALARM_CAUSE,
	output logic [4:0]      AREA_ALGO,
	output logic [7:0]      SMOKE_REPORT,
	output logic [7:0]      TEMP_REPORT,
	output logic            REPORT_VALID
);
	// ==========================================================
	// helpers
	// number of flagged intervals in a period
	function automatic logic [4:0] flag_count(input logic [19:0] f);
		logic [4:0] n;
		n = 5'h00;
		for (int i = 0; i < 20; i++) begin
			n = n + {4'h0, f[i]};
		end
		return n;
	endfunction : flag_count

	// saturating counter step, never below zero
	function automatic logic [3:0] count_step(input logic [3:0] c, input logic up,
		input logic [3:0] inc);
		logic [4:0] s;
		s = {1'b0, c} + {1'b0, inc};
		if (up) begin
			return (s > {1'b0, dadl_pkg::COUNT_MAX}) ? dadl_pkg::COUNT_MAX : s[3:0];
		end
		return (c < dadl_pkg::COUNT_DOWN) ? 4'h0 : c - dadl_pkg::COUNT_DOWN;
	endfunction : count_step

	// ==========================================================
	// one-second tick
	logic [27:0] tick_cnt;      // cycles inside the current second
	logic        tick;          // one-cycle pulse per second
	assign tick = CE && (tick_cnt == 28'(TICK_CYCLES - 1));

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			tick_cnt <= 28'h0;
		end else if (CE) begin
			tick_cnt <= tick ? 28'h0 : tick_cnt + 28'h1;
		end
	end

	// ==========================================================
	// algorithm and threshold compares
	dadl_pkg::dadl_algo_t algo;         // current area algorithm
	logic smoke_hi, temp_hi, rise_hi, comb_hi, heat_hi;
	assign smoke_hi = SMOKE >= SMOKE_THR;
	assign temp_hi  = TEMP >= TEMP_THR;
	assign rise_hi  = (RISE >= RISE_THR) && (algo != dadl_pkg::ALGO_HEATER);
	assign comb_hi  = COMBINED >= COMB_THR;
	assign heat_hi  = temp_hi || rise_hi;

	// ==========================================================
	// alarm counters
	logic [3:0] cnt_smoke;      // smoke counter
	logic [3:0] cnt_heat;       // temperature and rise counter
	logic [3:0] cnt_comb;       // combined index counter
	dadl_pkg::dadl_state_t state;

	// smoke and combined steps; heat steps
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			cnt_smoke <= 4'h0;
			cnt_heat  <= 4'h0;
			cnt_comb  <= 4'h0;
		end else if (tick && state == dadl_pkg::ST_IDLE) begin
			cnt_smoke <= count_step(cnt_smoke, smoke_hi, dadl_pkg::COUNT_UP_SLOW);
			cnt_heat  <= count_step(cnt_heat, heat_hi, dadl_pkg::COUNT_UP_FAST);
			cnt_comb  <= count_step(cnt_comb, comb_hi, dadl_pkg::COUNT_UP_SLOW);
		end
	end

	// ==========================================================
	// sixty second obscuration window
	logic [7:0]  win_mem [0:59];    // last sixty samples
	logic [5:0]  win_ptr;           // oldest entry
	logic        win_full;          // all sixty entries written
	logic [13:0] win_sum;           // running sum of the window
	logic [13:0] pre_alarm_average; // window sum held at the crossing, sixty times mean
	logic        smoke_was_hi;      // smoke above threshold last second
	logic [7:0]  win_old;
	assign win_old = win_full ? win_mem[win_ptr] : 8'h00;

	// window store; no reset on the array, the fill flag hides stale entries
	always_ff @(posedge CLOCK) begin
		if (tick) begin
			win_mem[win_ptr] <= SMOKE;
		end
	end

	// running sum, captured when the threshold is crossed
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			win_ptr           <= 6'h00;
			win_full          <= 1'b0;
			win_sum           <= 14'h0;
			pre_alarm_average <= 14'h0;
			smoke_was_hi      <= 1'b0;
		end else if (tick) begin
			win_ptr      <= (win_ptr == 6'd59) ? 6'h00 : win_ptr + 6'h01;
			win_full     <= win_full || (win_ptr == 6'd59);
			win_sum      <= win_sum + {6'h0, SMOKE} - {6'h0, win_old};
			smoke_was_hi <= smoke_hi;
			// sum taken before this second joins it
			if (smoke_hi && !smoke_was_hi && state == dadl_pkg::ST_IDLE) begin
				pre_alarm_average <= win_sum;
			end
		end
	end

	// ==========================================================
	// delay sequence
	dadl_pkg::dadl_cause_t cause;   // cause that reached the trigger
	logic [6:0]  elapsed;           // seconds since trigger
	logic [3:0]  acc_cnt;           // seconds summed so far
	logic signed [12:0] smoke_excess_sum;
	logic signed [12:0] combined_excess_sum;
	logic        trigger;
	logic        cancel_hi;
	logic [6:0]  delay_target;
	logic        due;
	assign trigger = (cnt_smoke >= dadl_pkg::COUNT_TRIGGER) ||
		(cnt_heat >= dadl_pkg::COUNT_TRIGGER) || (cnt_comb >= dadl_pkg::COUNT_TRIGGER);
	assign cancel_hi = ({1'b0, SMOKE} >= {SMOKE_THR, 1'b0}) || temp_hi || rise_hi;

	// band delay from the held window sum
	function automatic logic [6:0] band_delay(input logic [13:0] s, input logic clean);
		logic [13:0] lo, mi, hi;
		lo = 14'(clean ? dadl_pkg::BP_CLEAN_LOW : dadl_pkg::BP_LOW) * 14'(dadl_pkg::WINDOW_SECONDS);
		mi = 14'(clean ? dadl_pkg::BP_CLEAN_MID : dadl_pkg::BP_MID) * 14'(dadl_pkg::WINDOW_SECONDS);
		hi = 14'(clean ? dadl_pkg::BP_CLEAN_HIGH : dadl_pkg::BP_HIGH) * 14'(dadl_pkg::WINDOW_SECONDS);
		if (s < lo) begin
			return dadl_pkg::DELAY_LONG;
		end else if (s < mi) begin
			return dadl_pkg::DELAY_MID;
		end else if (s < hi) begin
			return dadl_pkg::DELAY_SHORT;
		end
		return dadl_pkg::DELAY_MIN;
	endfunction : band_delay

	// delay target for the held cause
	always_comb begin
		logic [12:0] raw;
		raw = 13'h0;
		case (cause)
			dadl_pkg::CAUSE_SMOKE: begin
				raw = {6'h0, band_delay(pre_alarm_average, algo == dadl_pkg::ALGO_CLEAN)};
				// smoke-steam lengthens by half the excess
				if (algo == dadl_pkg::ALGO_SMOKE && !smoke_excess_sum[12]) begin
					raw = raw + 13'(smoke_excess_sum >>> 1);
				end
			end
			dadl_pkg::CAUSE_COMB: begin
				// half the sum, the whole sum when cooking
				if (combined_excess_sum[12]) begin
					raw = 13'h0;
				end else if (algo == dadl_pkg::ALGO_COOK) begin
					raw = 13'(combined_excess_sum);
				end else begin
					raw = 13'(combined_excess_sum >>> 1);
				end
			end
			// heat causes use the fixed delay
			default: raw = {6'h0, dadl_pkg::DELAY_MIN};
		endcase
		delay_target = (raw > {6'h0, dadl_pkg::DELAY_CAP}) ? dadl_pkg::DELAY_CAP : raw[6:0];
	end

	// due once the sums are complete and the delay has run
	// or after eighteen seconds on a strong signal
	assign due = (acc_cnt == 4'(dadl_pkg::EXCESS_SECONDS) && elapsed >= delay_target) ||
		(elapsed >= dadl_pkg::CANCEL_SECONDS && cancel_hi);

	// sequence state and cause
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			state <= dadl_pkg::ST_IDLE;
			cause <= dadl_pkg::CAUSE_SMOKE;
		end else if (tick) begin
			case (state)
				dadl_pkg::ST_IDLE: begin
					// heat reaches the trigger fastest, so it wins a tie
					if (trigger) begin
						state <= dadl_pkg::ST_DELAY;
						if (cnt_heat >= dadl_pkg::COUNT_TRIGGER) begin
							cause <= dadl_pkg::CAUSE_HEAT;
						end else if (cnt_smoke >= dadl_pkg::COUNT_TRIGGER) begin
							cause <= dadl_pkg::CAUSE_SMOKE;
						end else begin
							cause <= dadl_pkg::CAUSE_COMB;
						end
					end
				end
				// fire stays latched until reset; the panel owns the restore
				dadl_pkg::ST_DELAY: if (due) begin
					state <= dadl_pkg::ST_FIRE;
				end
				dadl_pkg::ST_FIRE: state <= dadl_pkg::ST_FIRE;
				default: state <= dadl_pkg::ST_IDLE;
			endcase
		end
	end

	// excess sums over nine seconds after the trigger
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			elapsed             <= 7'h00;
			acc_cnt             <= 4'h0;
			smoke_excess_sum    <= 13'sh0;
			combined_excess_sum <= 13'sh0;
		end else if (tick) begin
			if (state != dadl_pkg::ST_DELAY) begin
				elapsed             <= 7'h00;
				acc_cnt             <= 4'h0;
				smoke_excess_sum    <= 13'sh0;
				combined_excess_sum <= 13'sh0;
			end else begin
				elapsed <= (elapsed == 7'h7f) ? elapsed : elapsed + 7'h01;
				if (acc_cnt < 4'(dadl_pkg::EXCESS_SECONDS)) begin
					acc_cnt <= acc_cnt + 4'h1;
					smoke_excess_sum <= smoke_excess_sum +
						13'(signed'({1'b0, SMOKE}) - signed'({1'b0, SMOKE_THR}));
					combined_excess_sum <= combined_excess_sum +
						13'(signed'({1'b0, COMBINED}) - signed'({1'b0, COMB_THR}));
				end
			end
		end
	end

	assign FIRE_ALARM   = state == dadl_pkg::ST_FIRE;
	assign DELAY_ACTIVE = state == dadl_pkg::ST_DELAY;
	assign ALARM_CAUSE  = cause;

	// ==========================================================
	// learning levels and interval flags
	logic [2:0]  level_hi;          // levels exceeded this second
	logic [2:0]  hit;               // levels exceeded in this interval
	logic [19:0] flags [0:2];       // per level interval flags
	logic [4:0]  cnt_level [0:2];   // flagged intervals including this one
	logic [4:0]  interval_idx;      // interval inside the period
	logic [17:0] interval_tick;     // seconds inside the interval
	logic        month_done;        // one full period since power on
	logic        interval_end;
	assign level_hi[0] = {SMOKE, 1'b0} >= {1'b0, SMOKE_THR};
	assign level_hi[1] = RISE >= dadl_pkg::LEVEL2_RISE;
	// combined with smoke and rise floors
	assign level_hi[2] = (COMBINED >= dadl_pkg::LEVEL3_COMB) &&
		(SMOKE >= dadl_pkg::LEVEL3_SMOKE) && (RISE >= dadl_pkg::LEVEL3_RISE);
	assign interval_end = tick && (interval_tick == 18'(INTERVAL_TICKS - 1));

	// interval timing; period wraps and keeps flags
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			interval_tick <= 18'h0;
			interval_idx  <= 5'h00;
			month_done    <= 1'b0;
		end else if (tick) begin
			interval_tick <= interval_end ? 18'h0 : interval_tick + 18'h1;
			if (interval_end) begin
				interval_idx <= (interval_idx == 5'd19) ? 5'h00 : interval_idx + 5'h01;
				month_done   <= month_done || (interval_idx == 5'd19);
			end
		end
	end

	for (genvar g = 0; g < 3; g++) begin : g_level
		logic [19:0] live;      // flags with this interval's hit shown
		always_comb begin
			live = flags[g];
			live[interval_idx] = flags[g][interval_idx] | hit[g];
		end
		assign cnt_level[g] = flag_count(live);
		// hit sticks for the interval; old flag refreshed at its end
		always_ff @(posedge CLOCK or negedge RESETN) begin
			if (!RESETN) begin
				hit[g]   <= 1'b0;
				flags[g] <= 20'h0;
			end else if (tick) begin
				if (interval_end) begin
					flags[g][interval_idx] <= hit[g] | level_hi[g];
					hit[g]                 <= 1'b0;
				end else if (level_hi[g]) begin
					hit[g] <= 1'b1;
				end
			end
		end
	end

	// normal from reset, moved only by learning
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			algo <= dadl_pkg::ALGO_NORMAL;
		end else if (CE) begin
			// adopt at three; fall back below three
			if (cnt_level[2] >= dadl_pkg::ADOPT_COUNT) begin
				algo <= dadl_pkg::ALGO_COOK;
			end else if (cnt_level[1] >= dadl_pkg::ADOPT_COUNT) begin
				algo <= dadl_pkg::ALGO_HEATER;
			end else if (cnt_level[0] >= dadl_pkg::ADOPT_COUNT) begin
				algo <= dadl_pkg::ALGO_SMOKE;
			// clean needs a spotless month; any flag leaves it
			end else if (month_done && cnt_level[0] == 5'h00 && cnt_level[1] == 5'h00 &&
				cnt_level[2] == 5'h00) begin
				algo <= dadl_pkg::ALGO_CLEAN;
			end else begin
				algo <= dadl_pkg::ALGO_NORMAL;
			end
		end
	end
	assign AREA_ALGO = algo;

	// ==========================================================
	// analog reporting
	logic [7:0] rep_hist [0:2];     // previous three obscuration samples
	logic [9:0] rep_sum;
	assign rep_sum = {2'b0, SMOKE} + {2'b0, rep_hist[0]} + {2'b0, rep_hist[1]} +
		{2'b0, rep_hist[2]};

	// four second mean and temperature each second
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			rep_hist[0]  <= 8'h00;
			rep_hist[1]  <= 8'h00;
			rep_hist[2]  <= 8'h00;
			SMOKE_REPORT <= 8'h00;
			TEMP_REPORT  <= 8'h00;
			REPORT_VALID <= 1'b0;
		end else if (CE) begin
			REPORT_VALID <= tick;
			if (tick) begin
				rep_hist[0]  <= SMOKE;
				rep_hist[1]  <= rep_hist[0];
				rep_hist[2]  <= rep_hist[1];
				SMOKE_REPORT <= rep_sum[9:2];
				TEMP_REPORT  <= TEMP;
			end
		end
	end

	// ==========================================================
	// checks
	chk_delay_cap: assert property (@(posedge CLOCK) disable iff (!RESETN)
		delay_target <= dadl_pkg::DELAY_CAP) else $error("delay above cap");
	chk_heat_fixed: assert property (@(posedge CLOCK) disable iff (!RESETN)
		cause == dadl_pkg::CAUSE_HEAT |-> delay_target == dadl_pkg::DELAY_MIN)
		else $error("heat delay not nine");
	chk_fire_after_delay: assert property (@(posedge CLOCK) disable iff (!RESETN)
		$rose(FIRE_ALARM) |-> ($past(elapsed) >= $past(delay_target) &&
		$past(acc_cnt) == 4'(dadl_pkg::EXCESS_SECONDS)) ||
		($past(elapsed) >= dadl_pkg::CANCEL_SECONDS && $past(cancel_hi)))
		else $error("fire before delay");
	chk_cancel_fire: assert property (@(posedge CLOCK) disable iff (!RESETN)
		tick && DELAY_ACTIVE && elapsed >= dadl_pkg::CANCEL_SECONDS && cancel_hi
		|=> FIRE_ALARM) else $error("strong signal did not end delay");
	chk_sum_length: assert property (@(posedge CLOCK) disable iff (!RESETN)
		DELAY_ACTIVE && elapsed >= 7'(dadl_pkg::EXCESS_SECONDS)
		|-> acc_cnt == 4'(dadl_pkg::EXCESS_SECONDS)) else $error("excess sum length");
	chk_adopt_smoke: assert property (@(posedge CLOCK) disable iff (!RESETN)
		CE && cnt_level[0] >= 5'h03 && cnt_level[1] < 5'h03 && cnt_level[2] < 5'h03
		|=> algo == dadl_pkg::ALGO_SMOKE) else $error("smoke algorithm not adopted");
	chk_clean_month: assert property (@(posedge CLOCK) disable iff (!RESETN)
		algo == dadl_pkg::ALGO_CLEAN |-> $past(month_done)) else $error("clean too early");
	chk_clean_leave: assert property (@(posedge CLOCK) disable iff (!RESETN)
		CE && algo == dadl_pkg::ALGO_CLEAN && (hit != 3'h0)
		|=> algo != dadl_pkg::ALGO_CLEAN) else $error("clean kept with a flag");
	chk_report_rate: assert property (@(posedge CLOCK) disable iff (!RESETN)
		tick |=> REPORT_VALID ##1 !REPORT_VALID) else $error("report not per second");
	chk_counter_trigger: assert property (@(posedge CLOCK) disable iff (!RESETN)
		tick && state == dadl_pkg::ST_IDLE && trigger |=> DELAY_ACTIVE)
		else $error("trigger did not start delay");
	cov_smoke_fire: cover property (@(posedge CLOCK) disable iff (!RESETN)
		cause == dadl_pkg::CAUSE_SMOKE && $rose(FIRE_ALARM));
	cov_comb_fire: cover property (@(posedge CLOCK) disable iff (!RESETN)
		cause == dadl_pkg::CAUSE_COMB && $rose(FIRE_ALARM));
	cov_adopt_cook: cover property (@(posedge CLOCK) disable iff (!RESETN)
		algo == dadl_pkg::ALGO_COOK);
	cov_clean: cover property (@(posedge CLOCK) disable iff (!RESETN)
		algo == dadl_pkg::ALGO_CLEAN);
endmodule : dadl_top
`default_nettype wire

// ### tb/dadl_panel.sv
// loop panel model: takes each obscuration report from the detector
`timescale 1ns/1ps
`default_nettype none
module dadl_panel (
	input  wire logic       clock,
	input  wire logic       resetn,
	input  wire logic       valid,
	input  wire logic [7:0] smoke,
	output logic [7:0]      got_smoke
);
	// ==========================================================
	// capture on the one-cycle pulse only; between pulses the value is stale
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			got_smoke <= 8'h00;
		end else if (valid) begin
			got_smoke <= smoke;
		end
	end
endmodule : dadl_panel
`default_nettype wire

// ### tb/testbench.sv
// self-checking bench for the alarm delay and learning block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic       clock = 1'b0;     // 200 MHz
	logic       resetn = 1'b0;    // active low
	logic [7:0] smoke = 8'h00;    // sensor samples
	logic [7:0] temp = 8'h14;
	logic [7:0] rise = 8'h00;
	logic [7:0] comb = 8'h00;
	logic       ce = 1'b1;        // clock enable
	logic [7:0] sthr = 8'h28;     // smoke fire threshold
	logic       fire, dact, rv;   // design outputs
	logic [2:0] cause;
	logic [4:0] algo;
	logic [7:0] srep, trep, got;
	int         n_errors = 0;
	int         cmp_count = 0;
	// ==========================================================
	// short tick and interval keep the month-long learning in reach
	dadl_top #(.TICK_CYCLES(4), .INTERVAL_TICKS(5)) dadl_top_i (.CLOCK(clock),
		.RESETN(resetn), .CE(ce), .SMOKE(smoke), .TEMP(temp), .RISE(rise),
		.COMBINED(comb), .SMOKE_THR(sthr), .TEMP_THR(8'h39), .RISE_THR(8'h12),
		.COMB_THR(8'h0c), .FIRE_ALARM(fire), .DELAY_ACTIVE(dact), .ALARM_CAUSE(cause),
		.AREA_ALGO(algo), .SMOKE_REPORT(srep), .TEMP_REPORT(trep), .REPORT_VALID(rv));
	dadl_panel dadl_panel_i (.clock(clock), .resetn(resetn), .valid(rv), .smoke(srep),
		.got_smoke(got));
	always #2.5 clock = ~clock;
	// ==========================================================
	// helpers
	task chk(input bit ok, input string m);
		cmp_count++;
		if (!ok) begin
			n_errors++;
			$display("unexpected %0t %s", $time, m);
		end
	endtask : chk
	task stop_test();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	// reset for three cycles, first sample value applied meanwhile
	task do_reset(input logic [7:0] s);
		@(posedge clock);
		resetn <= 1'b0;
		smoke <= s;
		temp <= 8'h14;
		rise <= 8'h00;
		comb <= 8'h00;
		ce <= 1'b1;
		sthr <= 8'h28;
		repeat (3) @(posedge clock);
		resetn <= 1'b1;
	endtask : do_reset
	// ==========================================================
	// reported obscuration is the mean of the last four samples
	task report_case();
		int i;
		do_reset(8'h00);
		chk(fire === 1'b0 && dact === 1'b0 && cause === 3'h1 && algo === 5'h01, "reset");
		for (i = 1; i <= 6; i++) begin
			@(posedge clock);
			smoke <= 8'(4 * i);
			temp <= 8'(i);
			while (rv !== 1'b1) @(negedge clock);
			@(negedge clock);
			if (i >= 4) chk(got === 8'(4 * i - 6) && trep === 8'(i), "report");
		end
		// enable dropped mid-second: no tick, so the new temperature is not taken
		@(posedge clock);
		ce <= 1'b0;
		temp <= 8'h33;
		repeat (20) @(negedge clock);
		chk(rv === 1'b0 && trep === 8'h06, "enable low");
		@(posedge clock);
		ce <= 1'b1;
		while (rv !== 1'b1) @(negedge clock);
		chk(trep === 8'h33, "enable high");
	endtask : report_case
	// pre-alarm level, then alarm inputs; delay measured start to alarm
	task alarm_case(input logic [7:0] pre, s, t, c, input logic [2:0] cz, input int d);
		int n;
		do_reset(pre);
		repeat (256) @(posedge clock);
		smoke <= s;
		temp <= t;
		comb <= c;
		n = 0;
		while (dact !== 1'b1 && n < 80) begin
			@(negedge clock);
			n++;
		end
		chk(dact === 1'b1 && cause === cz && fire === 1'b0, "delay start");
		n = 0;
		while (fire !== 1'b1 && n < 300) begin
			@(negedge clock);
			n++;
		end
		chk(n >= 4 * d && n <= 4 * d + 8, "delay length");
	endtask : alarm_case
	// level held from reset: adopt in the third interval, leave later
	task learn_case(input logic [7:0] s, r, c, input logic [4:0] a);
		int n;
		do_reset(s);
		rise <= r;
		comb <= c;
		repeat (42) @(negedge clock);
		chk(algo === 5'h01, "early adopt");
		n = 0;
		while (algo !== a && n < 20) begin
			@(negedge clock);
			n++;
		end
		chk(algo === a, "adopt");
		@(posedge clock);
		smoke <= 8'h00;
		rise <= 8'h00;
		comb <= 8'h00;
		n = 0;
		while (algo !== 5'h01 && n < 600) begin
			@(negedge clock);
			n++;
		end
		chk(algo === 5'h01 && n > 8, "return");
	endtask : learn_case
	// clean only after a whole quiet month, left at the first hit
	task clean_case();
		int n;
		do_reset(8'h00);
		repeat (300) @(negedge clock);
		chk(algo === 5'h01, "clean early");
		n = 0;
		while (algo !== 5'h10 && n < 200) begin
			@(negedge clock);
			n++;
		end
		chk(algo === 5'h10, "clean");
		// a lower threshold makes this sample a level one hit
		@(posedge clock);
		sthr <= 8'h20;
		smoke <= 8'h10;
		repeat (7) @(negedge clock);
		chk(algo === 5'h01, "clean leave");
	endtask : clean_case
	// ==========================================================
	// main sequence
	initial begin
		report_case();
		alarm_case(8'h00, 8'h28, 8'h14, 8'h00, 3'h1, 45);
		alarm_case(8'h07, 8'h28, 8'h14, 8'h00, 3'h1, 30);
		alarm_case(8'h0a, 8'h28, 8'h14, 8'h00, 3'h1, 18);
		alarm_case(8'h1e, 8'h28, 8'h14, 8'h00, 3'h1, 9);
		alarm_case(8'h1e, 8'h2a, 8'h14, 8'h00, 3'h1, 18);
		alarm_case(8'h00, 8'h50, 8'h14, 8'h00, 3'h1, 18);
		alarm_case(8'h00, 8'h00, 8'h40, 8'h00, 3'h2, 9);
		alarm_case(8'h00, 8'h00, 8'h14, 8'h0e, 3'h4, 9);
		learn_case(8'h14, 8'h00, 8'h00, 5'h02);
		learn_case(8'h00, 8'h0c, 8'h00, 5'h04);
		learn_case(8'h19, 8'h03, 8'h0a, 5'h08);
		clean_case();
		stop_test();
	end
	// watchdog, well beyond the expected run of about 24 us
	initial begin
		#200us;
		n_errors++;
		stop_test();
	end
endmodule : testbench
`default_nettype wire
